// *** bench/flash_cmd_props.sv ***
// Port assertions for the flash command block
// Assumes a bind to the top module and a single clock
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_props (
	input wire logic       ref_clk,
	input wire logic       reset,
	input wire logic       ce,
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic       array_start,
	input wire logic       array_abort,
	input wire logic [7:0] array_cmd
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	// ----------------
	// Checks
	// ----------------
	chk_start_pulse: assert property (array_start && ce |=> !array_start)
		else $error("start pulse too long");
	chk_start_legal: assert property (array_start |->
		array_cmd inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41})
		else $error("array started with a bad code");
	chk_cmd_hold: assert property ($changed(array_cmd) |-> array_start)
		else $error("array code moved without a start");
	chk_abort_pulse: assert property (array_abort && ce |=> !array_abort)
		else $error("abort pulse too long");
	// Both halves taken at one edge; halves are held a cycle, answer follows
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready && ce ##1 ce |=> s_axi_bvalid)
		else $error("write answer late");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
		else $error("read answer late");
	chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	cover property (array_start && array_cmd == 8'h25);
	cover property (array_abort);
	cover property (s_axi_bvalid && !s_axi_awready);
endmodule

bind flash_eeprom_command_status flash_cmd_props u_props (
	.ref_clk, .reset, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.array_start, .array_abort, .array_cmd);
`default_nettype wire

// *** bench/tb.sv ***
// Self-checking bench for the flash command block
// Assumes the block alone; the bench plays bus master and array engine
`include "flash_cmd_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        ref_clk = 0, reset = 1, awv = 0, wv = 0, arv = 0;
	logic        stop_mode = 0, array_done = 0, array_blank = 0;
	logic [7:0]  awa = 0, ara = 0, lcmd;
	logic [15:0] laddr;
	logic [31:0] wd = 0, d;
	wire         awr, wr_rdy, bv, arr, rv, irq, st_p, ab_p;
	wire  [1:0]  br, rr;
	wire  [31:0] rdat;
	wire  [7:0]  acmd;
	wire  [15:0] aadr;
	int          mismatches = 0, cmp_count = 0, starts = 0, aborts = 0, cyc = 0;
	flash_eeprom_command_status DUT (
		.ref_clk(ref_clk), .reset(reset), .ce(1'h1), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(1'h1), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'h1),
		.stop_mode(stop_mode), .array_done(array_done), .array_blank(array_blank),
		.array_start(st_p), .array_cmd(acmd), .array_addr(aadr), .array_abort(ab_p),
		.irq(irq));
	// ----------------
	// Clock, watchdog, array monitor
	// ----------------
	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (st_p === 1'h1) begin
			starts <= starts + 1;
			lcmd <= acmd;
			laddr <= aadr;
		end
		if (ab_p === 1'h1)
			aborts <= aborts + 1;
		if (cyc == 5000) begin
			mismatches++;
			give_verdict;
		end
	end
	task give_verdict;
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic ck(input string n, input logic [31:0] g, e);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// Ready lines are tied high, so each answer is taken when seen
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r = 2'h0);
		awa <= a;
		wd <= v;
		awv <= 1'h1;
		wv <= 1'h1;
		do begin
			@(posedge ref_clk);
			if (awr) awv <= 1'h0;
			if (wr_rdy) wv <= 1'h0;
		end while (!bv);
		ck("bresp", br, r);
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] r = 2'h0);
		ara <= a;
		arv <= 1'h1;
		do @(posedge ref_clk); while (!arr);
		arv <= 1'h0;
		do @(posedge ref_clk); while (!rv);
		d = rdat;
		ck("rresp", rr, r);
	endtask
	task automatic st(input logic [7:0] e);
		rd(`OFF_FLASH_STATUS);
		ck("status", d, e);
	endtask
	task automatic go(input logic [7:0] c, input logic [31:0] a);
		wr(`OFF_FLASH_COMMAND, c);
		wr(`OFF_TARGET_ADDR, a);
		wr(`OFF_FLASH_STATUS, 32'h80);
		repeat (2) @(posedge ref_clk);
	endtask
	// Completion flag settles two cycles after done
	task automatic fin(input logic b);
		array_blank <= b;
		array_done <= 1'h1;
		@(posedge ref_clk);
		array_done <= 1'h0;
		repeat (3) @(posedge ref_clk);
	endtask
	// ----------------
	// Scenarios
	// ----------------
	task automatic t_regs;
		st(8'hc0);
		rd(`OFF_IRQ_MASK);
		ck("mask", d, 0);
		rd(8'h1c, 2'h2);
		wr(8'h1c, 32'hff, 2'h2);
		wr(`OFF_FLASH_STATUS, 32'h44);
		st(8'hc0);
		go(8'h20, 32'h10);
		st(8'hd0);
		wr(`OFF_FLASH_STATUS, 32'h0);
		st(8'hd0);
		wr(`OFF_FLASH_STATUS, 32'h10);
		st(8'hc0);
		ck("starts", starts, 0);
		wr(`OFF_FLASH_CLOCK_DIV, 32'h13);
		$display("end regs");
	endtask
	task automatic t_codes;
		logic [7:0] bad [4] = '{8'h00, 8'h21, 8'h48, 8'hff};
		logic [7:0] c [6] = '{8'h05, 8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
		foreach (bad[i]) begin
			go(bad[i], 0);
			st(8'hd0);
			wr(`OFF_FLASH_STATUS, 32'h10);
		end
		ck("starts", starts, 0);
		for (int i = 0; i < 6; i++) begin
			go(c[i], 32'h100 + i);
			ck("cmd", lcmd, c[i]);
			ck("addr", laddr, 32'h100 + i);
			st(8'h80);
			fin(i == 0);
			st(i == 0 ? 8'hc4 : 8'hc0);
		end
		ck("starts", starts, 6);
		wr(`OFF_FLASH_STATUS, 32'h80);
		st(8'hd0);
		wr(`OFF_FLASH_STATUS, 32'h10);
		$display("end codes");
	endtask
	task automatic t_burst;
		go(8'h25, 32'h200);
		go(8'h25, 32'h201);
		st(8'h00);
		ck("starts", starts, 7);
		fin(0);
		st(8'h80);
		ck("addr", laddr, 32'h201);
		fin(0);
		st(8'hc0);
		$display("end burst");
	endtask
	task automatic t_prot;
		wr(`OFF_PROTECT, 32'h18000);
		go(8'h20, 32'h8000);
		st(8'he0);
		wr(`OFF_FLASH_STATUS, 32'h0);
		st(8'he0);
		go(8'h20, 32'h7fff);
		st(8'hf0);
		wr(`OFF_FLASH_STATUS, 32'h30);
		go(8'h20, 32'h7fff);
		fin(0);
		st(8'hc0);
		ck("starts", starts, 9);
		wr(`OFF_PROTECT, 32'hffff);
		$display("end protect");
	endtask
	task automatic t_stop;
		go(8'h40, 32'h300);
		stop_mode <= 1'h1;
		repeat (3) @(posedge ref_clk);
		stop_mode <= 1'h0;
		st(8'hd0);
		ck("aborts", aborts, 1);
		wr(`OFF_FLASH_STATUS, 32'h10);
		go(8'h40, 32'h400);
		go(8'h47, 32'h400);
		ck("aborts", aborts, 2);
		ck("cmd", lcmd, 8'h40);
		fin(0);
		go(8'h47, 32'h0);
		ck("aborts", aborts, 2);
		st(8'hc0);
		$display("end stop");
	endtask
	task automatic t_irq;
		wr(`OFF_IRQ_MASK, 32'h4);
		rd(`OFF_IRQ_STATUS);
		go(8'h00, 0);
		repeat (2) @(posedge ref_clk);
		ck("irq", irq, 1);
		rd(`OFF_IRQ_STATUS);
		ck("irq_status", d, 32'h4);
		repeat (2) @(posedge ref_clk);
		ck("irq", irq, 0);
		wr(`OFF_FLASH_STATUS, 32'h10);
		wr(`OFF_IRQ_MASK, 32'h3);
		go(8'h00, 0);
		repeat (2) @(posedge ref_clk);
		ck("irq", irq, 0);
		$display("end irq");
	endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		reset <= 1'h0;
		@(posedge ref_clk);
		t_regs;
		t_codes;
		t_burst;
		t_prot;
		t_stop;
		t_irq;
		give_verdict;
	end
endmodule
`default_nettype wire

// *** logic/flash_cmd_regs.vh ***
// Register map, field positions, command codes and reset values
// Assumes a 32-bit AXI4-Lite slave with one register per aligned word
`ifndef FLASH_CMD_REGS_VH
`define FLASH_CMD_REGS_VH

// ----------------------------------------
// Byte offsets
// ----------------------------------------
`define OFF_FLASH_STATUS    8'h00
`define OFF_FLASH_COMMAND   8'h04
`define OFF_FLASH_CLOCK_DIV 8'h08
`define OFF_TARGET_ADDR     8'h0c
`define OFF_PROTECT         8'h10
`define OFF_IRQ_STATUS      8'h14
`define OFF_IRQ_MASK        8'h18

// ----------------------------------------
// Status field positions
// ----------------------------------------
`define BIT_CBEF   7
`define BIT_CCF    6
`define BIT_PVIOL  5
`define BIT_ACCERR 4
`define BIT_BLANK  2

// Protect register: bit 16 enable, 15:0 lowest protected address
`define BIT_PROT_EN 16

// Interrupt status bits
`define IRQ_DONE   0
`define IRQ_PVIOL  1
`define IRQ_ACCERR 2

// ----------------------------------------
// Command codes
// ----------------------------------------
`define CMD_BLANK       8'h05
`define CMD_BYTE_PROG   8'h20
`define CMD_BURST_PROG  8'h25
`define CMD_SECT_ERASE  8'h40
`define CMD_MASS_ERASE  8'h41
`define CMD_ERASE_ABORT 8'h47

// ----------------------------------------
// Reset values and bus answers
// ----------------------------------------
`define RST_COMMAND   8'h00
`define RST_CLOCK_DIV 8'h00
`define RST_ADDR      16'h0000
`define RST_PROT_BASE 16'hffff
`define RST_IRQ_MASK  3'h0
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// *** logic/flash_eeprom_command_status.v ***
// Command launch and status logic of a flash and EEPROM controller
// Assumes an array engine that takes a start pulse and answers with done
// Contract
// - Writing one to buffer-empty launches; a buffered burst moving to array frees it
// - Only burst programs are buffered; buffer-empty reads zero while buffer full
// - Complete flag set when buffer empty and idle; cleared on launch
// - Software writes to the complete flag are ignored
// - Program or erase hitting protected area sets violation flag, command dropped
// - Violation flag clears only by writing one to it
// - Wrong command write sequence sets access error and drops command
// - Program or erase before clock divider written sets access error
// - Entering stop mode while a command runs sets access error
// - Access error clears by writing one; writing zero does nothing
// - Blank check end sets blank flag only if whole array erased
// - Blank flag cleared by a valid launch; software writes ignored
// - Six command codes accepted: 05, 20, 25, 40, 41, 47
// - Any other command code raises access error
// - Code 47 aborts a sector erase in progress
`include "flash_cmd_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module flash_eeprom_command_status (
	input  wire        ref_clk,
	input  wire        reset,
	input  wire        ce,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        stop_mode,
	input  wire        array_done,
	input  wire        array_blank,
	output reg         array_start,
	output reg  [7:0]  array_cmd,
	output reg  [15:0] array_addr,
	output reg         array_abort,
	output reg         irq
);

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function legal_cmd;
		input [7:0] c;
		begin
			legal_cmd = (c == `CMD_BLANK) || (c == `CMD_BYTE_PROG) ||
				(c == `CMD_BURST_PROG) || (c == `CMD_SECT_ERASE) ||
				(c == `CMD_MASS_ERASE) || (c == `CMD_ERASE_ABORT);
		end
	endfunction

	function prog_erase;
		input [7:0] c;
		begin
			prog_erase = (c == `CMD_BYTE_PROG) || (c == `CMD_BURST_PROG) ||
				(c == `CMD_SECT_ERASE) || (c == `CMD_MASS_ERASE);
		end
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg [7:0]  aw_addr_reg;
	reg        aw_held_reg;
	reg [31:0] w_data_reg;
	reg [3:0]  w_strb_reg;
	reg        w_held_reg;
	reg [7:0]  command_reg;
	reg [7:0]  clock_div_reg;
	reg        div_written_reg;
	reg [15:0] target_addr_reg;
	reg [15:0] prot_base_reg;
	reg        prot_en_reg;
	reg        cmd_loaded_reg;
	reg        busy_reg;
	reg [7:0]  cur_cmd_reg;
	reg        buf_full_reg;
	reg [15:0] buf_addr_reg;
	reg        ccf_reg;
	reg        pviol_reg;
	reg        accerr_reg;
	reg        blank_reg;
	reg [2:0]  irq_status_reg;
	reg [2:0]  irq_mask_reg;

	wire [7:0] status_val = {~buf_full_reg, ccf_reg, pviol_reg, accerr_reg,
		1'b0, blank_reg, 2'b00};

	// ----------------------------------------
	// Write decode
	// ----------------------------------------
	wire wr_go   = aw_held_reg & w_held_reg & ~s_axi_bvalid;
	wire wr_stat = wr_go & (aw_addr_reg == `OFF_FLASH_STATUS) & w_strb_reg[0];
	wire wr_cmd  = wr_go & (aw_addr_reg == `OFF_FLASH_COMMAND) & w_strb_reg[0];
	wire wr_div  = wr_go & (aw_addr_reg == `OFF_FLASH_CLOCK_DIV) & w_strb_reg[0];
	wire wr_addr = wr_go & (aw_addr_reg == `OFF_TARGET_ADDR);
	wire wr_prot = wr_go & (aw_addr_reg == `OFF_PROTECT);
	wire wr_mask = wr_go & (aw_addr_reg == `OFF_IRQ_MASK) & w_strb_reg[0];
	wire wr_map  = (aw_addr_reg == `OFF_FLASH_STATUS) |
		(aw_addr_reg == `OFF_FLASH_COMMAND) |
		(aw_addr_reg == `OFF_FLASH_CLOCK_DIV) |
		(aw_addr_reg == `OFF_TARGET_ADDR) | (aw_addr_reg == `OFF_PROTECT) |
		(aw_addr_reg == `OFF_IRQ_STATUS) | (aw_addr_reg == `OFF_IRQ_MASK);

	// ----------------------------------------
	// Launch qualification
	// ----------------------------------------
	// one written to a set buffer-empty bit
	wire launch = wr_stat & w_data_reg[`BIT_CBEF] & ~buf_full_reg;
	wire is_abort = (command_reg == `CMD_ERASE_ABORT);
	wire is_burst = (command_reg == `CMD_BURST_PROG);
	// only a burst behind a running burst may queue
	wire can_queue = is_burst & (cur_cmd_reg == `CMD_BURST_PROG);
	// sequence broken, also launch over pending errors
	wire seq_err = ~cmd_loaded_reg | pviol_reg | accerr_reg |
		(busy_reg & ~can_queue & ~is_abort);
	wire code_err = ~legal_cmd(command_reg);
	wire div_err = prog_erase(command_reg) & ~div_written_reg;
	wire acc_hit = launch & (seq_err | code_err | div_err);
	wire prot_hit = launch & ~acc_hit & prot_en_reg & prog_erase(command_reg) &
		((command_reg == `CMD_MASS_ERASE) | (target_addr_reg >= prot_base_reg));
	wire launch_ok = launch & ~acc_hit & ~prot_hit;
	wire stop_hit = stop_mode & busy_reg;
	wire done_ev = busy_reg & array_done & ~stop_hit;
	wire ccf_set = ~ccf_reg & ~busy_reg & ~buf_full_reg & ~launch_ok;
	wire rd_irq = s_axi_arvalid & s_axi_arready & (s_axi_araddr == `OFF_IRQ_STATUS);

	// ----------------------------------------
	// Bus handshakes
	// ----------------------------------------
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
			aw_held_reg   <= 1'b0;
			w_held_reg    <= 1'b0;
			aw_addr_reg   <= 8'h00;
			w_data_reg    <= 32'h0000_0000;
			w_strb_reg    <= 4'h0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RESP_OKAY;
		end else if (ce) begin
			s_axi_awready <= ~aw_held_reg & ~(s_axi_awvalid & s_axi_awready);
			s_axi_wready  <= ~w_held_reg & ~(s_axi_wvalid & s_axi_wready);
			if (s_axi_awvalid & s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_held_reg   <= 1'b0;
				w_held_reg    <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
			s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `RESP_OKAY;
				case (s_axi_araddr)
					`OFF_FLASH_STATUS: s_axi_rdata <= {24'h000000, status_val};
					`OFF_FLASH_COMMAND: s_axi_rdata <= {24'h000000, command_reg};
					`OFF_FLASH_CLOCK_DIV: s_axi_rdata <= {24'h000000, clock_div_reg};
					`OFF_TARGET_ADDR: s_axi_rdata <= {16'h0000, target_addr_reg};
					`OFF_PROTECT: s_axi_rdata <= {15'h0000, prot_en_reg, prot_base_reg};
					`OFF_IRQ_STATUS: s_axi_rdata <= {29'h00000000, irq_status_reg};
					`OFF_IRQ_MASK: s_axi_rdata <= {29'h00000000, irq_mask_reg};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			command_reg     <= `RST_COMMAND;
			clock_div_reg   <= `RST_CLOCK_DIV;
			div_written_reg <= 1'b0;
			target_addr_reg <= `RST_ADDR;
			prot_base_reg   <= `RST_PROT_BASE;
			prot_en_reg     <= 1'b0;
			irq_mask_reg    <= `RST_IRQ_MASK;
			cmd_loaded_reg  <= 1'b0;
		end else if (ce) begin
			if (wr_cmd)
				command_reg <= w_data_reg[7:0];
			if (wr_div) begin
				clock_div_reg   <= w_data_reg[7:0];
				div_written_reg <= 1'b1;
			end
			if (wr_addr & w_strb_reg[0])
				target_addr_reg[7:0] <= w_data_reg[7:0];
			if (wr_addr & w_strb_reg[1])
				target_addr_reg[15:8] <= w_data_reg[15:8];
			if (wr_prot & w_strb_reg[0])
				prot_base_reg[7:0] <= w_data_reg[7:0];
			if (wr_prot & w_strb_reg[1])
				prot_base_reg[15:8] <= w_data_reg[15:8];
			if (wr_prot & w_strb_reg[2])
				prot_en_reg <= w_data_reg[`BIT_PROT_EN];
			if (wr_mask)
				irq_mask_reg <= w_data_reg[2:0];
			// each launch consumes the loaded command
			if (wr_cmd)
				cmd_loaded_reg <= 1'b1;
			else if (launch)
				cmd_loaded_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Command engine and status flags
	// ----------------------------------------
	// Error flags use set-wins so no event is lost to a clear
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			busy_reg       <= 1'b0;
			cur_cmd_reg    <= 8'h00;
			buf_full_reg   <= 1'b0;
			buf_addr_reg   <= 16'h0000;
			ccf_reg        <= 1'b1;
			pviol_reg      <= 1'b0;
			accerr_reg     <= 1'b0;
			blank_reg      <= 1'b0;
			array_start    <= 1'b0;
			array_cmd      <= 8'h00;
			array_addr     <= 16'h0000;
			array_abort    <= 1'b0;
			irq_status_reg <= 3'h0;
			irq            <= 1'b0;
		end else if (ce) begin
			array_start <= 1'b0;
			array_abort <= 1'b0;
			if (stop_hit) begin
				// run is cut short, queue dropped
				busy_reg     <= 1'b0;
				buf_full_reg <= 1'b0;
				array_abort  <= 1'b1;
			end else if (launch_ok & is_abort) begin
				// abort only touches a running sector erase
				// A done in the same cycle must still end the run
				if (done_ev)
					busy_reg <= 1'b0;
				else if (busy_reg & (cur_cmd_reg == `CMD_SECT_ERASE))
					array_abort <= 1'b1;
			end else if (launch_ok & busy_reg & ~done_ev) begin
				buf_full_reg <= 1'b1;
				buf_addr_reg <= target_addr_reg;
			end else if (launch_ok) begin
				busy_reg    <= 1'b1;
				cur_cmd_reg <= command_reg;
				array_start <= 1'b1;
				array_cmd   <= command_reg;
				array_addr  <= target_addr_reg;
			end else if (done_ev & buf_full_reg) begin
				buf_full_reg <= 1'b0;
				array_start  <= 1'b1;
				array_cmd    <= `CMD_BURST_PROG;
				array_addr   <= buf_addr_reg;
			end else if (done_ev) begin
				busy_reg <= 1'b0;
			end
			// complete when idle and empty, cleared on launch
			// status writes never reach this flag
			if (launch_ok)
				ccf_reg <= 1'b0;
			else if (ccf_set)
				ccf_reg <= 1'b1;
			pviol_reg <= prot_hit |
				(pviol_reg & ~(wr_stat & w_data_reg[`BIT_PVIOL]));
			accerr_reg <= acc_hit | stop_hit |
				(accerr_reg & ~(wr_stat & w_data_reg[`BIT_ACCERR]));
			if (launch_ok)
				blank_reg <= 1'b0;
			// set only by an erased array at blank check end
			else if (done_ev & (cur_cmd_reg == `CMD_BLANK))
				blank_reg <= array_blank;
			// Read clears, new events win over the clear
			irq_status_reg <= (irq_status_reg & {3{~rd_irq}}) |
				{acc_hit | stop_hit, prot_hit, ccf_set};
			irq <= |(irq_status_reg & irq_mask_reg);
		end
	end

endmodule

`default_nettype wire
